/* File: tdmcf_cfg.svh */
// addresses, field positions, reset values and select codes of the dual mode compare timer
// What this block does
// - top bit of high clock select set splits counter into two 8-bit counters
// - high select: 000-011 cascade, 100 /32, 101 /16, 110 /4, 111 watch/4
// - low select: top bit 0 external event edges (011 none), else /32 /16 /4 watch/4
// - external event active edge chosen by outside edge-select bit
// - 8-bit mode: each half clears on own match when its clear enable set
// - 8-bit mode: half wrap FF to 00 sets overflow flag, request if enabled
// - 16-bit mode: 16-bit match sets high match flag and high request flag
// - 8-bit mode: each half matches its own compare half independently
// - 16-bit mode: high toggle pin inverts on every 16-bit match
// - 8-bit mode: each toggle pin inverts on its own half match
// - writing output level bits drives pins low or high right after write
// - both compare halves reset to all ones
// - 16-bit compare value is high half above low half
// - 16-bit mode: counter and compare bytes pass through one temporary latch
// - control register is 8-bit, write-only, resets to 00
// - status register resets 00: ovf, match, ovf irq enable, clear per half
// - status flags set by hardware only; writes can only clear them
// - 8-bit mode: high match flag set whenever high counter equals high compare
// - enabling event pin function while pin low may count once
// - 16-bit mode: upper write goes to latch; lower write loads both bytes together
// - 16-bit mode: upper counter read captures lower byte into latch for next lower read
// - 16-bit mode: wrap FFFF to 0000 sets high overflow flag
`ifndef TDMCF_CFG_SVH
`define TDMCF_CFG_SVH
`define TDMCF_ADDR_CTRL 16'hFFB6
`define TDMCF_ADDR_STAT 16'hFFB7
`define TDMCF_ADDR_CNTH 16'hFFB8
`define TDMCF_ADDR_CNTL 16'hFFB9
`define TDMCF_ADDR_CMPH 16'hFFBA
`define TDMCF_ADDR_CMPL 16'hFFBB
`define TDMCF_CTRL_RST 8'h00
`define TDMCF_STAT_RST 8'h00
`define TDMCF_CNT_RST 8'h00
`define TDMCF_CMP_RST 8'hFF
`define TDMCF_IDLE_RD 8'hFF
`define TDMCF_HALF_MAX 8'hFF
`define TDMCF_CTRL_HLVL 7
`define TDMCF_CTRL_HSEL 6:4
`define TDMCF_CTRL_HTOP 6
`define TDMCF_CTRL_LLVL 3
`define TDMCF_CTRL_LSEL 2:0
`define TDMCF_ST_HOVF 7
`define TDMCF_ST_HMAT 6
`define TDMCF_ST_HOVIE 5
`define TDMCF_ST_HCLR 4
`define TDMCF_ST_LOVF 3
`define TDMCF_ST_LMAT 2
`define TDMCF_ST_LOVIE 1
`define TDMCF_ST_LCLR 0
`define TDMCF_FLAG_MASK 8'hCC
`define TDMCF_CS_NONE 3'h3
`define TDMCF_CS_D32 3'h4
`define TDMCF_CS_D16 3'h5
`define TDMCF_CS_D4 3'h6
`define TDMCF_CS_W4 3'h7
`define TDMCF_CS_TOP 2
`endif

/* File: tdmcf_pkg.sv */
// state types of the dual mode compare timer
package tdmcf_pkg;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] stat;
    logic [7:0] arm;
    logic [7:0] cnt_h;
    logic [7:0] cnt_l;
    logic [7:0] cmp_h;
    logic [7:0] cmp_l;
    logic [7:0] temp;
    logic [7:0] rdata;
    logic tog_h;
    logic tog_l;
    logic irf_h;
    logic irf_l;
    logic irq_h;
    logic irq_l;
    logic meq_h;
    logic meq_l;
  } tdmcf_state_t;
  typedef struct packed {
    logic [3:0] lvl;
    logic tick;
  } tdmcf_sel_state_t;
  typedef struct packed {
    logic eff;
    logic pulse;
  } tdmcf_evt_state_t;
endpackage

/* File: tdmcf_src_if.sv */
// clock select code and count enable between the timer core and a source selector
`timescale 1ns/10ps
interface tdmcf_src_if;
  logic [2:0] sel;
  logic tick;
  modport ctl (output sel, input tick);
  modport gen (input sel, output tick);
endinterface

/* File: tdmcf_event.sv */
// external event pin conditioner: function gating and edge selection
`timescale 1ns/10ps
`include "tdmcf_cfg.svh"
module tdmcf_event (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic edge_rise_i,
  input wire logic func_en_i,
  output logic pulse_o
);
  import tdmcf_pkg::*;
  tdmcf_evt_state_t s_q, s_d;
  logic eff;
  always_comb begin
    s_d = s_q;
    // pin idles high while its function is off, so enabling it on a low pin looks like a fall
    eff = func_en_i ? pin_i : 1'b1;
    s_d.eff = eff;
    s_d.pulse = edge_rise_i ? (eff & ~s_q.eff) : (~eff & s_q.eff);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{eff: 1'b1, pulse: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end
  assign pulse_o = s_q.pulse;
endmodule // tdmcf_event

/* File: tdmcf_src_sel.sv */
// count source selector: prescaler phases or event pulse to a one-cycle enable
`timescale 1ns/10ps
`include "tdmcf_cfg.svh"
module tdmcf_src_sel (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] phase_i,
  input wire logic ext_pulse_i,
  tdmcf_src_if.gen src
);
  import tdmcf_pkg::*;
  tdmcf_sel_state_t s_q, s_d;
  logic [3:0] rise;
  always_comb begin
    s_d = s_q;
    s_d.lvl = phase_i;
    // each rising edge of the selected phase gives exactly one enable cycle
    rise = phase_i & ~s_q.lvl;
    unique case (src.sel)
      `TDMCF_CS_D32: s_d.tick = rise[0];
      `TDMCF_CS_D16: s_d.tick = rise[1];
      `TDMCF_CS_D4: s_d.tick = rise[2];
      `TDMCF_CS_W4: s_d.tick = rise[3];
      `TDMCF_CS_NONE: s_d.tick = 1'b0;
      default: s_d.tick = ext_pulse_i;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign src.tick = s_q.tick;
endmodule // tdmcf_src_sel

/* File: tdmcf_timer.sv */
// dual mode compare timer: counters, compare, flags, toggle pins and byte register port
`timescale 1ns/10ps
`include "tdmcf_cfg.svh"
module tdmcf_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic div32_i,
  input wire logic div16_i,
  input wire logic div4_i,
  input wire logic watch_div4_i,
  input wire logic event_input_pin_i,
  input wire logic event_edge_select_i,
  input wire logic event_pin_function_bit_i,
  input wire logic high_irq_enable_i,
  input wire logic low_irq_enable_i,
  input wire logic high_irq_clear_i,
  input wire logic low_irq_clear_i,
  output logic high_irq_request_flag_o,
  output logic low_irq_request_flag_o,
  output logic high_irq_o,
  output logic low_irq_o,
  output logic high_toggle_pin_o,
  output logic low_toggle_pin_o
);
  import tdmcf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////

  tdmcf_state_t s_q, s_d;
  tdmcf_src_if src_h ();
  tdmcf_src_if src_l ();
  logic ext_pulse;
  logic [3:0] phases;

  function automatic logic [7:0] inc8(input logic [7:0] v);
    inc8 = v + 8'h01;
  endfunction

  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  assign phases = {watch_div4_i, div4_i, div16_i, div32_i};
  assign src_h.sel = s_q.ctrl[`TDMCF_CTRL_HSEL];
  assign src_l.sel = s_q.ctrl[`TDMCF_CTRL_LSEL];

  tdmcf_event u_event (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(event_input_pin_i),
    .edge_rise_i(event_edge_select_i),
    .func_en_i(event_pin_function_bit_i),
    .pulse_o(ext_pulse)
  );

  tdmcf_src_sel u_sel_h (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .phase_i(phases),
    .ext_pulse_i(1'b0),
    .src(src_h.gen)
  );

  tdmcf_src_sel u_sel_l (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .phase_i(phases),
    .ext_pulse_i(ext_pulse),
    .src(src_l.gen)
  );

  ////////////////////////////////////////////////////////////////////////////////

  logic split;
  logic inc_l;
  logic inc_h;
  logic eq_h;
  logic eq_l;
  logic ovf_h;
  logic ovf_l;
  logic rise_h;
  logic rise_l;
  logic [15:0] wide;
  logic [7:0] set_m;
  logic [7:0] clr_m;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_cnth;
  logic wr_cntl;
  logic wr_cmph;
  logic wr_cmpl;

  always_comb begin
    s_d = s_q;
    split = s_q.ctrl[`TDMCF_CTRL_HTOP];
    wide = {s_q.cnt_h, s_q.cnt_l};
    inc_l = src_l.tick;
    inc_h = 1'b0;
    ovf_h = 1'b0;
    ovf_l = 1'b0;
    set_m = 8'h00;
    clr_m = 8'h00;
    wr_ctrl = wr_i && (addr_i == `TDMCF_ADDR_CTRL);
    wr_stat = wr_i && (addr_i == `TDMCF_ADDR_STAT);
    wr_cnth = wr_i && (addr_i == `TDMCF_ADDR_CNTH);
    wr_cntl = wr_i && (addr_i == `TDMCF_ADDR_CNTL);
    wr_cmph = wr_i && (addr_i == `TDMCF_ADDR_CMPH);
    wr_cmpl = wr_i && (addr_i == `TDMCF_ADDR_CMPL);

    // compare: whole word in 16-bit mode, each half alone in 8-bit mode
    if (split) begin
      eq_h = hit({8'h00, s_q.cnt_h}, {8'h00, s_q.cmp_h});
      eq_l = hit({8'h00, s_q.cnt_l}, {8'h00, s_q.cmp_l});
    end else begin
      eq_h = hit(wide, {s_q.cmp_h, s_q.cmp_l});
      eq_l = 1'b0;
    end
    rise_h = eq_h & ~s_q.meq_h;
    rise_l = eq_l & ~s_q.meq_l;
    s_d.meq_h = eq_h;
    s_d.meq_l = eq_l;

    ////////////////////////////////////////////////////////////////////////////
    // counting
    if (split) begin
      inc_h = src_h.tick;
      if (inc_l) begin
        if (s_q.stat[`TDMCF_ST_LCLR] && eq_l) begin
          s_d.cnt_l = `TDMCF_CNT_RST;
        end else begin
          ovf_l = (s_q.cnt_l == `TDMCF_HALF_MAX);
          s_d.cnt_l = inc8(s_q.cnt_l);
        end
      end
      if (inc_h) begin
        if (s_q.stat[`TDMCF_ST_HCLR] && eq_h) begin
          s_d.cnt_h = `TDMCF_CNT_RST;
        end else begin
          ovf_h = (s_q.cnt_h == `TDMCF_HALF_MAX);
          s_d.cnt_h = inc8(s_q.cnt_h);
        end
      end
    end else if (inc_l) begin
      // high half advances on the low half carry
      if (s_q.stat[`TDMCF_ST_HCLR] && eq_h) begin
        s_d.cnt_h = `TDMCF_CNT_RST;
        s_d.cnt_l = `TDMCF_CNT_RST;
      end else begin
        ovf_h = (s_q.cnt_h == `TDMCF_HALF_MAX) && (s_q.cnt_l == `TDMCF_HALF_MAX);
        s_d.cnt_l = inc8(s_q.cnt_l);
        if (s_q.cnt_l == `TDMCF_HALF_MAX) begin
          s_d.cnt_h = inc8(s_q.cnt_h);
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // toggle pins; a level write in the same cycle takes precedence
    if (rise_h) begin
      s_d.tog_h = ~s_q.tog_h;
    end
    if (rise_l) begin
      s_d.tog_l = ~s_q.tog_l;
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    if (wr_ctrl) begin
      s_d.ctrl = wdata_i;
      s_d.tog_h = wdata_i[`TDMCF_CTRL_HLVL];
      s_d.tog_l = wdata_i[`TDMCF_CTRL_LLVL];
    end
    if (wr_stat) begin
      // only flags seen as 1 by a previous read can be cleared
      clr_m = ~wdata_i & s_q.arm & `TDMCF_FLAG_MASK;
      s_d.stat = (s_q.stat & `TDMCF_FLAG_MASK) | (wdata_i & ~`TDMCF_FLAG_MASK);
      s_d.arm = 8'h00;
    end
    if (wr_cnth) begin
      if (split) begin
        s_d.cnt_h = wdata_i;
      end else begin
        s_d.temp = wdata_i;
      end
    end
    if (wr_cntl) begin
      s_d.cnt_l = wdata_i;
      if (!split) begin
        s_d.cnt_h = s_q.temp;
      end
    end
    if (wr_cmph) begin
      if (split) begin
        s_d.cmp_h = wdata_i;
      end else begin
        s_d.temp = wdata_i;
      end
    end
    if (wr_cmpl) begin
      s_d.cmp_l = wdata_i;
      if (!split) begin
        s_d.cmp_h = s_q.temp;
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flags: hardware set wins over a same-cycle clear
    set_m[`TDMCF_ST_HOVF] = ovf_h;
    set_m[`TDMCF_ST_HMAT] = eq_h;
    set_m[`TDMCF_ST_LOVF] = ovf_l;
    set_m[`TDMCF_ST_LMAT] = eq_l;
    s_d.stat = (s_d.stat & ~clr_m) | set_m;

    if (high_irq_clear_i) begin
      s_d.irf_h = 1'b0;
    end
    if (low_irq_clear_i) begin
      s_d.irf_l = 1'b0;
    end
    if (rise_h || (ovf_h && s_q.stat[`TDMCF_ST_HOVIE])) begin
      s_d.irf_h = 1'b1;
    end
    if (rise_l || (ovf_l && s_q.stat[`TDMCF_ST_LOVIE])) begin
      s_d.irf_l = 1'b1;
    end
    s_d.irq_h = s_d.irf_h & high_irq_enable_i;
    s_d.irq_l = s_d.irf_l & low_irq_enable_i;

    ////////////////////////////////////////////////////////////////////////////
    // register reads, answered on the next edge
    s_d.rdata = `TDMCF_IDLE_RD;
    if (rd_i) begin
      unique case (addr_i)
        `TDMCF_ADDR_STAT: begin
          s_d.rdata = s_q.stat;
          s_d.arm = s_q.arm | (s_q.stat & `TDMCF_FLAG_MASK);
        end
        `TDMCF_ADDR_CNTH: begin
          s_d.rdata = s_q.cnt_h;
          if (!split) begin
            s_d.temp = s_q.cnt_l;
          end
        end
        `TDMCF_ADDR_CNTL: begin
          s_d.rdata = split ? s_q.cnt_l : s_q.temp;
        end
        `TDMCF_ADDR_CMPH: begin
          s_d.rdata = s_q.cmp_h;
        end
        `TDMCF_ADDR_CMPL: begin
          s_d.rdata = s_q.cmp_l;
        end
        // control register is write-only and reads as idle
        default: begin
          s_d.rdata = `TDMCF_IDLE_RD;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.ctrl <= `TDMCF_CTRL_RST;
      s_q.stat <= `TDMCF_STAT_RST;
      s_q.cnt_h <= `TDMCF_CNT_RST;
      s_q.cnt_l <= `TDMCF_CNT_RST;
      s_q.cmp_h <= `TDMCF_CMP_RST;
      s_q.cmp_l <= `TDMCF_CMP_RST;
      s_q.rdata <= `TDMCF_IDLE_RD;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign high_irq_request_flag_o = s_q.irf_h;
  assign low_irq_request_flag_o = s_q.irf_l;
  assign high_irq_o = s_q.irq_h;
  assign low_irq_o = s_q.irq_l;
  assign high_toggle_pin_o = s_q.tog_h;
  assign low_toggle_pin_o = s_q.tog_l;
endmodule // tdmcf_timer

/* File: tdmcf_monitor.sv */
// assertion checker on the dual mode compare timer ports
`timescale 1ns/10ps
module tdmcf_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic high_irq_enable_i,
  input wire logic low_irq_enable_i,
  input wire logic high_irq_clear_i,
  input wire logic high_irq_request_flag_o,
  input wire logic low_irq_request_flag_o,
  input wire logic high_irq_o,
  input wire logic low_irq_o,
  input wire logic high_toggle_pin_o,
  input wire logic low_toggle_pin_o
);
  logic [3:0] en_q;
  logic mode8_q;
  wire ctl_wr = wr_i && addr_i == 16'hFFB6;
  // shadow of what software last wrote, to judge read-back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 4'h0;
      mode8_q <= 1'b0;
    end else begin
      if (wr_i && addr_i == 16'hFFB7) en_q <= {wdata_i[5:4], wdata_i[1:0]};
      if (ctl_wr) mode8_q <= wdata_i[6];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_high_irq_gate: assert property (high_irq_o == (high_irq_request_flag_o && $past(high_irq_enable_i)))
    else $error("high irq output disagrees with flag and enable");
  a_low_irq_gate: assert property (low_irq_o == (low_irq_request_flag_o && $past(low_irq_enable_i)))
    else $error("low irq output disagrees with flag and enable");
  a_idle_read_ff: assert property (!$past(rd_i) || $past(addr_i) == 16'hFFB6 |-> rdata_o == 8'hFF)
    else $error("read data not idle outside a readable access");
  a_level_write: assert property (ctl_wr |=> {high_toggle_pin_o, low_toggle_pin_o} == {$past(wdata_i[7]), $past(wdata_i[3])})
    else $error("toggle pins do not follow written levels");
  a_toggle_has_cause: assert property ($changed(high_toggle_pin_o) && !$past(ctl_wr) |-> high_irq_request_flag_o)
    else $error("high toggle moved without a match");
  a_flag_clear_only: assert property ($fell(high_irq_request_flag_o) |-> $past(high_irq_clear_i))
    else $error("high request flag dropped without a clear");
  a_enable_readback: assert property ($past(rd_i && addr_i == 16'hFFB7) |-> {rdata_o[5:4], rdata_o[1:0]} == $past(en_q))
    else $error("status enable bits read back wrong");
  a_low_quiet_wide: assert property (!mode8_q && !$past(mode8_q) |-> !$rose(low_irq_request_flag_o))
    else $error("low request flag rose in 16-bit mode");
  c_high_irq: cover property (high_irq_o);
  c_low_toggle: cover property ($changed(low_toggle_pin_o) && !$past(ctl_wr));
  c_low_flag: cover property ($rose(low_irq_request_flag_o));
endmodule // tdmcf_monitor

/* File: tdmcf_prescale_model.sv */
// prescaler phase model feeding the divided clock inputs
`timescale 1ns/10ps
module tdmcf_prescale_model (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic div32_o,
  output logic div16_o,
  output logic div4_o,
  output logic watch_div4_o
);
  logic [4:0] cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) cnt_q <= 5'h00;
    else cnt_q <= cnt_q + 5'h01;
  end
  assign div32_o = cnt_q[4];
  assign div16_o = cnt_q[3];
  assign div4_o = cnt_q[1];
  // watch rate arbitrary here; asynchronous on real silicon
  assign watch_div4_o = cnt_q[2];
endmodule // tdmcf_prescale_model

/* File: tdmcf_bench.sv */
// self-checking bench of the dual mode compare timer
`timescale 1ns/10ps
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin bad_count++; $display("mismatch %0t %s", $time, m); end end
module dual_mode_compare_timer_bench;
  localparam logic [15:0] CT = 16'hFFB6, ST = 16'hFFB7, CH = 16'hFFB8, CL = 16'hFFB9, PH = 16'hFFBA, PL = 16'hFFBB;
  logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, pin = 1'b0, esel = 1'b1, func = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00, rdata_o;
  logic hen = 1'b1, len = 1'b1, hclr = 1'b0, lclr = 1'b0, hflag, lflag, hirq, lirq, htog, ltog, tog;
  logic d32, d16, d4, dw;
  int bad_count = 0, n_checks = 0, cycles = 0;
  tdmcf_prescale_model i_tdmcf_prescale_model (.clk_i(clk_i), .rst_i(rst_i), .div32_o(d32), .div16_o(d16),
    .div4_o(d4), .watch_div4_o(dw));
  tdmcf_timer i_tdmcf_timer (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .div32_i(d32), .div16_i(d16), .div4_i(d4), .watch_div4_i(dw),
    .event_input_pin_i(pin), .event_edge_select_i(esel), .event_pin_function_bit_i(func),
    .high_irq_enable_i(hen), .low_irq_enable_i(len), .high_irq_clear_i(hclr), .low_irq_clear_i(lclr),
    .high_irq_request_flag_o(hflag), .low_irq_request_flag_o(lflag), .high_irq_o(hirq), .low_irq_o(lirq),
    .high_toggle_pin_o(htog), .low_toggle_pin_o(ltog));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(negedge clk_i);
    wr_i = 1'b0;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
    @(negedge clk_i);
    addr_i = a;
    rd_i = 1'b1;
    @(negedge clk_i);
    rd_i = 1'b0;
    `CHK(rdata_o & m, e & m, "read value")
  endtask
  // n full high/low cycles on the event pin, each level held five clocks
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (2) begin
        @(negedge clk_i);
        pin = ~pin;
        repeat (4) @(negedge clk_i);
      end
    end
  endtask
  task automatic clr_low;
    @(negedge clk_i);
    lclr = 1'b1;
    @(negedge clk_i);
    lclr = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk(ST, 8'h00, 8'hFF);
    rchk(PH, 8'hFF, 8'hFF);
    rchk(PL, 8'hFF, 8'hFF);
    rchk(CT, 8'hFF, 8'hFF);
    wr(CT, 8'h88);
    `CHK({htog, ltog}, 2'b11, "levels high")
    wr(CT, 8'h00);
    `CHK({htog, ltog}, 2'b00, "levels low")
  endtask
  task automatic t_match8;
    // split first so the lone compare byte lands directly
    wr(CT, 8'hC0);
    wr(PL, 8'h03);
    wr(ST, 8'h01);
    tog = ltog;
    pulse(3);
    rchk(CL, 8'h03, 8'hFF);
    `CHK(ltog, ~tog, "low toggle")
    `CHK({lflag, lirq}, 2'b11, "low request")
    len = 1'b0;
    @(negedge clk_i);
    `CHK(lirq, 1'b0, "low irq masked")
    len = 1'b1;
    rchk(ST, 8'h04, 8'h0C);
    pulse(1);
    rchk(CL, 8'h00, 8'hFF);
    rchk(ST, 8'h00, 8'h08);
    clr_low();
    `CHK(lflag, 1'b0, "low flag clear")
  endtask
  task automatic t_ovf8;
    wr(PL, 8'h10);
    wr(ST, 8'h02);
    wr(CL, 8'hFE);
    pulse(2);
    `CHK(lflag, 1'b1, "overflow request")
    rchk(CL, 8'h00, 8'hFF);
    wr(ST, 8'h02);
    rchk(ST, 8'h08, 8'h08);
    wr(ST, 8'h02);
    rchk(ST, 8'h00, 8'h08);
    wr(ST, 8'h0A);
    rchk(ST, 8'h00, 8'h08);
    clr_low();
  endtask
  task automatic t_wide;
    wr(CT, 8'h03);
    wr(CH, 8'hAA);
    wr(CL, 8'h55);
    wr(CH, 8'h77);
    rchk(CH, 8'hAA, 8'hFF);
    rchk(CL, 8'h55, 8'hFF);
    wr(PH, 8'h00);
    wr(PL, 8'h01);
    rchk(PH, 8'h00, 8'hFF);
    rchk(PL, 8'h01, 8'hFF);
    wr(CH, 8'hFF);
    wr(CL, 8'hFE);
    rchk(ST, 8'h00, 8'hC0);
    `CHK(hflag, 1'b0, "high request idle")
    wr(CT, 8'h06);
    // level bit of the control write forces the pin, so sample it afterwards
    tog = htog;
    repeat (40) @(negedge clk_i);
    `CHK({htog, hflag, hirq}, {~tog, 2'b11}, "wide match")
    wr(CT, 8'h03);
    rchk(ST, 8'hC0, 8'hC0);
    @(negedge clk_i);
    hclr = 1'b1;
    @(negedge clk_i);
    hclr = 1'b0;
    `CHK({hflag, hirq}, 2'b00, "high request clear")
  endtask
  task automatic t_event;
    wr(CT, 8'hC0);
    func = 1'b0;
    esel = 1'b0;
    repeat (4) @(negedge clk_i);
    wr(CL, 8'h00);
    func = 1'b1;
    repeat (5) @(negedge clk_i);
    rchk(CL, 8'h01, 8'hFF);
    pulse(1);
    rchk(CL, 8'h02, 8'hFF);
  endtask
  initial begin
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    t_reset();
    t_match8();
    t_ovf8();
    t_wide();
    t_event();
    summarize();
  end
endmodule // dual_mode_compare_timer_bench
bind tdmcf_timer tdmcf_monitor i_tdmcf_monitor (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i),
  .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .high_irq_enable_i(high_irq_enable_i),
  .low_irq_enable_i(low_irq_enable_i), .high_irq_clear_i(high_irq_clear_i),
  .high_irq_request_flag_o(high_irq_request_flag_o), .low_irq_request_flag_o(low_irq_request_flag_o),
  .high_irq_o(high_irq_o), .low_irq_o(low_irq_o), .high_toggle_pin_o(high_toggle_pin_o),
  .low_toggle_pin_o(low_toggle_pin_o));
